/* rrsp_defs.svh */
`ifndef RRSP_DEFS_SVH
`define RRSP_DEFS_SVH
`define RRSP_DW_MAX        256
`define RRSP_KEEP_W        8
`define RRSP_DWORD_W       32
`define RRSP_USER_W        60
`define RRSP_READY_W       4
`define RRSP_SEQ_W         4
`define RRSP_FIFO_DEPTH    32
`define RRSP_BE_FIRST_LSB  0
`define RRSP_BE_LAST_LSB   4
`define RRSP_OFFS_LSB      8
`define RRSP_BE_W          4
`define RRSP_OFFS_W        3
`define RRSP_SEQ_LSB       24
`define RRSP_WIDTH_64      2'h0
`define RRSP_WIDTH_128     2'h1
`define RRSP_WIDTH_256     2'h2
`define RRSP_KEEP_MASK_64  8'h03
`define RRSP_KEEP_MASK_128 8'h0F
`define RRSP_KEEP_MASK_256 8'hFF
`define RRSP_SEQ_LAT       3
`endif

/* rrsp_pkg.sv */
`include "rrsp_defs.svh"
package rrsp_pkg;
	typedef struct packed {
		logic [`RRSP_DW_MAX-1:0] data;
		logic [`RRSP_KEEP_W-1:0] keep;
		logic                    last;
		logic                    first;
		logic [`RRSP_BE_W-1:0]   head_be;
		logic [`RRSP_BE_W-1:0]   tail_be;
		logic [`RRSP_OFFS_W-1:0] offs;
		logic [`RRSP_SEQ_W-1:0]  seq;
	} rrsp_beat_t;
	typedef enum logic [0:0] {
		RRSP_HEAD = 1'b0,
		RRSP_BODY = 1'b1
	} rrsp_state_t;
endpackage

/* rrsp_fifo.sv */
module rrsp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input  wire logic             i_core_clk,
	input  wire logic             i_srst,
	input  wire logic [WIDTH-1:0] i_wr_data,
	input  wire logic             i_wr_valid,
	output logic                  o_wr_ready,
	output logic      [WIDTH-1:0] o_rd_data,
	output logic                  o_rd_valid,
	input  wire logic             i_rd_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wptr_r;
	logic [AW-1:0]    rptr_r;
	logic [AW:0]      cnt_r;
	logic             wr_en;
	logic             rd_en;

	// read data comes from a register; output slot refills when taken
	assign wr_en = i_wr_valid && o_wr_ready;
	assign rd_en = (cnt_r != '0) && (!o_rd_valid || i_rd_ready);

	always_ff @(posedge i_core_clk) begin
		if (wr_en) begin
			mem[wptr_r] <= i_wr_data;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			wptr_r <= '0;
			rptr_r <= '0;
			cnt_r  <= '0;
		end else begin
			if (wr_en) begin
				wptr_r <= wptr_r + 1'b1;
			end
			if (rd_en) begin
				rptr_r <= rptr_r + 1'b1;
			end
			cnt_r <= cnt_r + (AW+1)'(wr_en) - (AW+1)'(rd_en);
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			o_rd_valid <= 1'b0;
		end else if (rd_en) begin
			o_rd_valid <= 1'b1;
		end else if (i_rd_ready) begin
			o_rd_valid <= 1'b0;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (rd_en) begin
			o_rd_data <= mem[rptr_r];
		end
	end

	// registered full flag, counts one pending write conservatively
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			o_wr_ready <= 1'b0;
		end else begin
			o_wr_ready <= (cnt_r + (AW+1)'(wr_en) - (AW+1)'(rd_en)) < (AW+1)'(DEPTH - 1);
		end
	end
endmodule

/* rrsp_top.sv */
`include "rrsp_defs.svh"
module rrsp_top
	import rrsp_pkg::*;
(
	input  wire logic                       i_core_clk,
	input  wire logic                       i_srst,
	input  wire logic [1:0]                 i_configured_bus_width,
	input  wire logic [`RRSP_DW_MAX-1:0]    i_request_data_bus,
	input  wire logic [`RRSP_USER_W-1:0]    i_request_sideband_bus,
	input  wire logic                       i_request_end_of_packet,
	input  wire logic [`RRSP_KEEP_W-1:0]    i_request_dword_keep,
	input  wire logic                       i_request_beat_valid,
	output logic      [`RRSP_READY_W-1:0]   o_request_accept_ready,
	output logic      [`RRSP_SEQ_W-1:0]     o_request_progress_seq_out,
	output logic                            o_request_progress_seq_valid,
	output rrsp_beat_t                      o_tx_beat,
	output logic                            o_tx_valid,
	input  wire logic                       i_tx_ready
);
	localparam int BEAT_W = $bits(rrsp_beat_t);

	rrsp_state_t             state_r;
	rrsp_beat_t              in_beat;
	rrsp_beat_t              fifo_beat;
	logic                    fifo_wr_ready;
	logic                    fifo_rd_valid;
	logic                    take;
	logic                    out_take;
	logic [`RRSP_KEEP_W-1:0] keep_mask;
	logic [`RRSP_DW_MAX-1:0] data_mask;
	logic [`RRSP_BE_W-1:0]   head_be_r;
	logic [`RRSP_BE_W-1:0]   tail_be_r;
	logic [`RRSP_OFFS_W-1:0] offs_r;
	logic [`RRSP_SEQ_W-1:0]  seq_r;
	logic [`RRSP_BE_W-1:0]   side_head_be;
	logic [`RRSP_BE_W-1:0]   side_tail_be;
	logic [`RRSP_OFFS_W-1:0] side_offs;
	logic [`RRSP_SEQ_W-1:0]  side_seq;
	logic                    head_take;
	logic                    tail_take;

	// ----------------------------------------
	// input qualification
	// ----------------------------------------
	assign take = i_request_beat_valid && o_request_accept_ready[0];

	// keep lanes past the configured width are dropped
	always_comb begin
		unique case (i_configured_bus_width)
			`RRSP_WIDTH_64: begin
				keep_mask = `RRSP_KEEP_MASK_64;
			end
			`RRSP_WIDTH_128: begin
				keep_mask = `RRSP_KEEP_MASK_128;
			end
			// code 3 decodes as the widest bus
			default: begin
				keep_mask = `RRSP_KEEP_MASK_256;
			end
		endcase
	end

	// ----------------------------------------
	// per-dword lane enables
	// ----------------------------------------
	for (genvar g = 0; g < `RRSP_KEEP_W; g++) begin : g_lane
		// a lane past the configured width is forced to zero
		assign data_mask[g*`RRSP_DWORD_W +: `RRSP_DWORD_W] = {`RRSP_DWORD_W{keep_mask[g]}};
	end

	// ----------------------------------------
	// sideband fields
	// ----------------------------------------
	assign side_head_be = i_request_sideband_bus[`RRSP_BE_FIRST_LSB +: `RRSP_BE_W];
	assign side_tail_be = i_request_sideband_bus[`RRSP_BE_LAST_LSB +: `RRSP_BE_W];
	assign side_offs    = i_request_sideband_bus[`RRSP_OFFS_LSB +: `RRSP_OFFS_W];
	assign side_seq     = i_request_sideband_bus[`RRSP_SEQ_LSB +: `RRSP_SEQ_W];
	// body-beat sideband is never looked at
	assign head_take    = take && (state_r == RRSP_HEAD);

	// ----------------------------------------
	// packet parser
	// ----------------------------------------
	// idle cycles leave the parser where it is
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			state_r <= RRSP_HEAD;
		end else if (take) begin
			state_r <= i_request_end_of_packet ? RRSP_HEAD : RRSP_BODY;
		end
	end

	// ----------------------------------------
	// first-beat header field capture
	// ----------------------------------------
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			head_be_r <= '0;
			tail_be_r <= '0;
			offs_r    <= '0;
		end else if (head_take) begin
			head_be_r <= side_head_be;
			tail_be_r <= side_tail_be;
			offs_r    <= side_offs;
		end
	end

	// sequence tag travels with every beat of its packet
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			seq_r <= '0;
		end else if (head_take) begin
			seq_r <= side_seq;
		end
	end

	// ----------------------------------------
	// beat assembly
	// ----------------------------------------
	always_comb begin
		in_beat.data  = i_request_data_bus & data_mask;
		in_beat.keep  = i_request_dword_keep & keep_mask;
		in_beat.last  = i_request_end_of_packet;
		in_beat.first = (state_r == RRSP_HEAD);
		if (state_r == RRSP_HEAD) begin
			in_beat.head_be = side_head_be;
			in_beat.tail_be = side_tail_be;
			in_beat.offs    = side_offs;
			in_beat.seq     = side_seq;
		end else begin
			in_beat.head_be = head_be_r;
			in_beat.tail_be = tail_be_r;
			in_beat.offs    = offs_r;
			in_beat.seq     = seq_r;
		end
	end

	// ----------------------------------------
	// transmit buffer
	// ----------------------------------------
	// read side advances whenever the output slot is free
	rrsp_fifo #(
		.WIDTH (BEAT_W),
		.DEPTH (`RRSP_FIFO_DEPTH)
	) u_fifo (
		.i_core_clk (i_core_clk),
		.i_srst     (i_srst),
		.i_wr_data  (in_beat),
		.i_wr_valid (take),
		.o_wr_ready (fifo_wr_ready),
		.o_rd_data  (fifo_beat),
		.o_rd_valid (fifo_rd_valid),
		.i_rd_ready (out_take || !o_tx_valid)
	);

	// ----------------------------------------
	// request ready
	// ----------------------------------------
	// buffer full flag is already a register; a second stage here
	// would keep ready up one cycle after the buffer stopped writing
	assign o_request_accept_ready = {`RRSP_READY_W{fifo_wr_ready}};

	// ----------------------------------------
	// output stage
	// ----------------------------------------
	assign out_take = o_tx_valid && i_tx_ready;

	// slot refills only when empty or being taken
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			o_tx_valid <= 1'b0;
		end else if (out_take || !o_tx_valid) begin
			o_tx_valid <= fifo_rd_valid;
		end
	end

	// beat holds until the pipeline takes it
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			o_tx_beat <= '0;
		end else if (out_take || !o_tx_valid) begin
			o_tx_beat <= fifo_beat;
		end
	end

	// ----------------------------------------
	// sequence echo
	// ----------------------------------------
	// echo once the last beat leaves for the link pipeline
	assign tail_take = out_take && o_tx_beat.last;

	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			o_request_progress_seq_valid <= 1'b0;
		end else begin
			o_request_progress_seq_valid <= tail_take;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			o_request_progress_seq_out <= '0;
		end else if (tail_take) begin
			o_request_progress_seq_out <= o_tx_beat.seq;
		end
	end
endmodule

/* rrsp_checker.sv */
`include "rrsp_defs.svh"
module rrsp_checker
	import rrsp_pkg::*;
(
	input  wire logic                     i_core_clk,
	input  wire logic                     i_srst,
	input  wire logic [1:0]               i_configured_bus_width,
	input  wire logic [`RRSP_READY_W-1:0] o_request_accept_ready,
	input  wire logic [`RRSP_SEQ_W-1:0]   o_request_progress_seq_out,
	input  wire logic                     o_request_progress_seq_valid,
	input  wire rrsp_beat_t               o_tx_beat,
	input  wire logic                     o_tx_valid,
	input  wire logic                     i_tx_ready
);
	logic                    in_pkt_r;
	logic                    lt_r;
	logic [`RRSP_BE_W-1:0]   be_r;
	logic [`RRSP_KEEP_W-1:0] kmask;
	wire                     take = o_tx_valid & i_tx_ready;
	assign kmask = (i_configured_bus_width == `RRSP_WIDTH_64) ? `RRSP_KEEP_MASK_64 :
		(i_configured_bus_width == `RRSP_WIDTH_128) ? `RRSP_KEEP_MASK_128 : `RRSP_KEEP_MASK_256;
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			in_pkt_r <= 1'b0;
			lt_r <= 1'b0;
		end else begin
			in_pkt_r <= take ? !o_tx_beat.last : in_pkt_r;
			lt_r <= take & o_tx_beat.last;
		end
	end
	always_ff @(posedge i_core_clk) begin
		if (take) begin
			be_r <= o_tx_beat.head_be;
		end
	end
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_srst);
	sequence last_taken;
		take && o_tx_beat.last;
	endsequence
	a_ready_all_same: assert property (o_request_accept_ready inside {4'h0, 4'hF})
		else $error("ready bits differ");
	a_seq_echo_last: assert property (last_taken |=> o_request_progress_seq_valid &&
		o_request_progress_seq_out == $past(o_tx_beat.seq)) else $error("sequence echo wrong");
	a_seq_pulse_cause: assert property (o_request_progress_seq_valid == lt_r)
		else $error("sequence pulse wrong");
	a_tx_beat_hold: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_beat))
		else $error("beat changed while stalled");
	a_keep_high_masked: assert property (o_tx_valid |-> (o_tx_beat.keep & ~kmask) == 8'h00)
		else $error("keep above width");
	a_data_high_zero: assert property (o_tx_valid && i_configured_bus_width == `RRSP_WIDTH_64
		|-> o_tx_beat.data[255:64] == '0) else $error("data above width");
	a_first_after_last: assert property (o_tx_valid |-> o_tx_beat.first == !in_pkt_r)
		else $error("first flag wrong");
	a_head_be_held: assert property (o_tx_valid && in_pkt_r |-> o_tx_beat.head_be == be_r)
		else $error("head enables changed");
endmodule
bind rrsp_top rrsp_checker u_chk (.*);

/* rrsp_user_model.sv */
module rrsp_user_model (
	input  wire logic         i_core_clk,
	input  wire logic         i_ready,
	output logic      [255:0] o_data,
	output logic      [59:0]  o_side,
	output logic              o_eop,
	output logic      [7:0]   o_keep,
	output logic              o_valid
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		o_valid = 1'b0;
		o_data = '0;
		o_side = '0;
		o_eop = 1'b0;
		o_keep = 8'h00;
	end
	task automatic send(input int n, input logic [3:0] be, seq, input logic [7:0] kl);
		for (int i = 0; i < n; i++) begin
			o_valid <= 1'b1;
			o_data <= {32{8'(i)}};
			o_side <= {32'h0, seq, 16'h0, ~be, be};
			o_eop <= (i == n - 1);
			o_keep <= (i == n - 1) ? kl : 8'hFF;
			@(posedge i_core_clk);
			while (!i_ready) @(posedge i_core_clk);
		end
		o_valid <= 1'b0;
		o_data <= ~o_data;
		o_side <= ~o_side;
		@(posedge i_core_clk);
	endtask
endmodule

/* rrsp_top_tb.sv */
`include "rrsp_defs.svh"
module rrsp_top_tb;
	import rrsp_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic         clk = 0, i_srst = 1, txr = 1, eop, vld, sv, txv;
	logic [1:0]   w = `RRSP_WIDTH_256;
	logic [255:0] dat;
	logic [59:0]  sd;
	logic [7:0]   kp;
	logic [3:0]   rdy, so, last_seq;
	rrsp_beat_t   tx, q[$];
	int           miscompares = 0, num_checks = 0, pulses = 0;
	always #20 clk = ~clk;
	rrsp_top DUT (.i_core_clk(clk), .i_srst(i_srst), .i_configured_bus_width(w), .i_request_data_bus(dat),
		.i_request_sideband_bus(sd), .i_request_end_of_packet(eop), .i_request_dword_keep(kp),
		.i_request_beat_valid(vld), .o_request_accept_ready(rdy), .o_request_progress_seq_out(so),
		.o_request_progress_seq_valid(sv), .o_tx_beat(tx), .o_tx_valid(txv), .i_tx_ready(txr));
	rrsp_user_model u_user (.i_core_clk(clk), .i_ready(rdy[0]), .o_data(dat), .o_side(sd), .o_eop(eop),
		.o_keep(kp), .o_valid(vld));
	always @(posedge clk) begin
		if (txv && txr) q.push_back(tx);
		if (sv) pulses++;
		if (sv) last_seq <= so;
	end
	task automatic check(input string what, input logic [255:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("FAIL %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task automatic close_out();
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic drain(input int n);
		for (int i = 0; i < 300 && q.size() < n; i++) @(posedge clk);
		repeat (2) @(posedge clk);
		check("beats", q.size(), n);
	endtask
	task automatic t_single();
		q.delete();
		pulses = 0;
		u_user.send(1, 4'hA, 4'h5, 8'h07);
		drain(1);
		check("frame", {q[0].first, q[0].last}, 2'b11);
		check("keep", q[0].keep, 8'h07);
		check("tail", q[0].tail_be, 4'h5);
		check("pulses", pulses, 1);
		check("echo", last_seq, 4'h5);
	endtask
	task automatic t_fill();
		q.delete();
		txr <= 1'b0;
		fork u_user.send(40, 4'h3, 4'h9, 8'h01); join_none
		for (int i = 0; i < 200 && rdy !== 4'h0; i++) @(posedge clk);
		check("ready", rdy, 4'h0);
		check("held", q.size(), 0);
		txr <= 1'b1;
		wait fork;
		drain(40);
		foreach (q[i]) begin
			check("be", {q[i].head_be, q[i].seq, q[i].last}, {4'h3, 4'h9, i == 39});
			check("kp", q[i].keep, i == 39 ? 8'h01 : 8'hFF);
		end
	endtask
	task automatic t_widths();
		logic [7:0] km[3] = '{8'h03, 8'h0F, 8'hFF};
		int sh[3] = '{192, 128, 0};
		for (int k = 0; k < 3; k++) begin
			q.delete();
			w <= 2'(k);
			@(posedge clk);
			u_user.send(2, 4'hF, 4'(k), 8'hFF);
			drain(2);
			check("kmask", q[1].keep, km[k]);
			check("dmask", q[1].data, {32{8'h01}} & ({256{1'b1}} >> sh[k]));
		end
	endtask
	initial begin
		#200000;
		miscompares++;
		close_out();
	end
	initial begin
		repeat (16) @(posedge clk);
		check("rst", {rdy, txv, sv}, 6'h00);
		i_srst <= 1'b0;
		for (int i = 0; i < 20 && rdy !== 4'hF; i++) @(posedge clk);
		t_single();
		t_fill();
		t_widths();
		close_out();
	end
endmodule
